// [boot_remap_pkg.sv]
// package: memory map, flash geometry, boot and flash-command types
// Summary of operation
// RQ1: every reset starts in the boot rom while the flash checksum is computed
// RQ2: matching checksum hands over to flash, otherwise stay in rom mode
// RQ3: in rom mode the 4 KB rom repeats 16 times over the first 64 KB
// RQ4: in rom mode program flash decodes at 0x10000 to 0x17FFF
// RQ5: in rom mode data flash decodes at 0x18800 to 0x18FFF
// RQ6: in rom mode data ram decodes at 0x19000 to 0x19FFF
// RQ7: valid checksum or a transfer command switches to the normal map
// RQ8: vectors come from rom in rom mode, from program flash otherwise
// RQ9: each flash has its own programming logic and is unreadable while busy
// RQ10: flash is programmed one word at a time, erased only by blocks
// RQ11: data flash has 64 erasable blocks of 32 bytes
// RQ12: program flash has 32 erasable blocks of 1 KB
// RQ13: erase leaves every erased bit at one
// RQ14: programmer erases, writes blocks, optionally verifies, then starts the program
// RQ15: running code may erase program flash by page or whole array
// RQ16: an all-zero stored checksum keeps the next boot in rom mode
// RQ17: code changing program flash runs from rom, ram or data flash
// RQ18: code in one flash may erase or write another flash
// RQ19: never two flash write or erase operations at once
// RQ20: one shared bus serves fetch and data for every memory
// RQ21: checksum is a word sum; stored word is the last program flash word
package boot_remap_pkg;

    localparam logic [16:0] ROM_MIRROR_HI = 17'h0FFFF;
    localparam logic [16:0] PF_LO         = 17'h10000;
    localparam logic [16:0] PF_HI         = 17'h17FFF;
    localparam logic [16:0] DF_LO         = 17'h18800;
    localparam logic [16:0] DF_HI         = 17'h18FFF;
    localparam logic [16:0] RAM_LO        = 17'h19000;
    localparam logic [16:0] RAM_HI        = 17'h19FFF;
    localparam logic [16:0] NPF_LO        = 17'h00000;
    localparam logic [16:0] NPF_HI        = 17'h07FFF;
    localparam logic [16:0] NROM_LO       = 17'h10000;
    localparam logic [16:0] NROM_HI       = 17'h10FFF;

    localparam logic [3:0]  SEL_ROM       = 4'h1;
    localparam logic [3:0]  SEL_PF        = 4'h2;
    localparam logic [3:0]  SEL_DF        = 4'h4;
    localparam logic [3:0]  SEL_RAM       = 4'h8;

    localparam int          PF_PAGES      = 32;
    localparam int          DF_PAGES      = 64;
    localparam logic [12:0] PF_PAGE_MASK  = 13'h00FF;
    localparam logic [12:0] DF_PAGE_MASK  = 13'h0007;
    localparam logic [12:0] PF_LAST       = 13'h1FFF;
    localparam logic [12:0] DF_LAST       = 13'h01FF;
    localparam logic [12:0] CKSUM_IDX     = 13'h1FFF;
    localparam logic [31:0] ERASED        = 32'hFFFFFFFF;

    typedef enum logic [2:0] {
        BOOT_SCAN   = 3'b001,
        BOOT_ROM    = 3'b010,
        BOOT_NORMAL = 3'b100
    } boot_t;

    typedef enum logic [1:0] {
        OP_PROG = 2'h0,
        OP_PAGE = 2'h1,
        OP_MASS = 2'h2
    } flash_op_t;

    typedef struct packed {
        flash_op_t   op;
        logic        arr;
        logic [12:0] addr;
        logic [31:0] data;
    } flash_cmd_t;

    typedef struct packed {
        logic        en;
        logic        we;
        logic [12:0] addr;
        logic [31:0] wdata;
    } flash_port_t;

    typedef struct packed {
        logic [3:0]  sel;
        logic [14:0] offs;
        logic        err;
    } bus_dec_t;

    typedef struct packed {
        logic        busy;
        flash_op_t   op;
        logic [12:0] addr;
        logic [12:0] last;
        logic [31:0] data;
    } flash_ctl_t;

    typedef struct packed {
        boot_t             boot;
        logic [12:0]       sidx;
        logic              sdone;
        logic              rv;
        logic [12:0]       ridx;
        logic [31:0]       sum;
        logic              cksum_ok;
        logic              rom_mode;
        bus_dec_t          dec;
        flash_ctl_t  [1:0] fc;
        flash_port_t [1:0] port;
        logic [1:0]        busy;
        logic              refused;
        logic              done;
    } state_t;

endpackage

// [boot_checksum_memory_remap.sv]
// boot checksum, address remap and flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none

module boot_checksum_memory_remap
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        cpu_req,
    input  wire logic                        cpu_we,
    input  wire logic [16:0]                 cpu_addr,
    input  wire logic                        goto_flash,
    input  wire logic                        cmd_valid,
    input  wire boot_remap_pkg::flash_cmd_t  cmd,
    input  wire logic [31:0]                 pf_rdata,
    output var boot_remap_pkg::bus_dec_t     dec,
    output logic                             rom_mode,
    output logic                             cksum_ok,
    output var boot_remap_pkg::flash_port_t  pf_port,
    output var boot_remap_pkg::flash_port_t  df_port,
    output logic [1:0]                       busy,
    output logic                             cmd_refused,
    output logic                             cmd_done
);

    boot_remap_pkg::state_t s;
    boot_remap_pkg::state_t next_s;

    always_comb
    begin
        logic        rm;
        logic        ok;
        logic [12:0] mask;
        logic [12:0] last;
        logic [12:0] base;
        rm   = 1'b0;
        ok   = 1'b0;
        mask = 13'h0000;
        last = 13'h0000;
        base = 13'h0000;
        next_s         = s;
        next_s.refused = 1'b0;
        next_s.done    = 1'b0;
        next_s.rv      = 1'b0;

        // one shared decode for fetch and data [RQ20]
        rm         = (s.boot != boot_remap_pkg::BOOT_NORMAL);
        next_s.dec = '0;
        if (cpu_req)
        begin
            // address 0 holds the vectors: rom or flash by mode [RQ8]
            if (rm && cpu_addr <= boot_remap_pkg::ROM_MIRROR_HI)
            begin
                next_s.dec.sel  = boot_remap_pkg::SEL_ROM; // [RQ3]
                next_s.dec.offs = {3'h0, cpu_addr[11:0]};
            end
            else if (!rm && cpu_addr >= boot_remap_pkg::NROM_LO
                     && cpu_addr <= boot_remap_pkg::NROM_HI)
            begin
                next_s.dec.sel  = boot_remap_pkg::SEL_ROM;
                next_s.dec.offs = {3'h0, cpu_addr[11:0]};
            end
            else if (rm ? (cpu_addr >= boot_remap_pkg::PF_LO
                           && cpu_addr <= boot_remap_pkg::PF_HI)
                        : (cpu_addr >= boot_remap_pkg::NPF_LO
                           && cpu_addr <= boot_remap_pkg::NPF_HI))
            begin
                next_s.dec.sel  = boot_remap_pkg::SEL_PF; // [RQ4]
                next_s.dec.offs = cpu_addr[14:0];
            end
            else if (cpu_addr >= boot_remap_pkg::DF_LO
                     && cpu_addr <= boot_remap_pkg::DF_HI)
            begin
                next_s.dec.sel  = boot_remap_pkg::SEL_DF; // [RQ5]
                next_s.dec.offs = {4'h0, cpu_addr[10:0]};
            end
            else if (cpu_addr >= boot_remap_pkg::RAM_LO
                     && cpu_addr <= boot_remap_pkg::RAM_HI)
            begin
                next_s.dec.sel  = boot_remap_pkg::SEL_RAM; // [RQ6]
                next_s.dec.offs = {3'h0, cpu_addr[11:0]};
            end
            // busy array blocks only itself, the other stays usable [RQ9] [RQ18]
            next_s.dec.err = (next_s.dec.sel == 4'h0)
                || (cpu_we && next_s.dec.sel != boot_remap_pkg::SEL_RAM) // [RQ10]
                || (next_s.dec.sel == boot_remap_pkg::SEL_PF
                    && (s.busy[0] || s.fc[0].busy
                        || s.boot == boot_remap_pkg::BOOT_SCAN))
                || (next_s.dec.sel == boot_remap_pkg::SEL_DF
                    && (s.busy[1] || s.fc[1].busy));
            if (next_s.dec.err)
            begin
                next_s.dec.sel  = 4'h0;
                next_s.dec.offs = 15'h0000;
            end
        end

        // independent sequencer per array [RQ9]
        for (int i = 0; i < 2; i++)
        begin
            next_s.port[i] = '0;
            if (s.fc[i].busy)
            begin
                next_s.port[i].en    = 1'b1;
                next_s.port[i].we    = 1'b1;
                next_s.port[i].addr  = s.fc[i].addr;
                next_s.port[i].wdata = (s.fc[i].op == boot_remap_pkg::OP_PROG)
                                     ? s.fc[i].data
                                     : boot_remap_pkg::ERASED; // [RQ13]
                if (s.fc[i].addr == s.fc[i].last)
                begin
                    next_s.fc[i].busy = 1'b0;
                    next_s.done       = 1'b1;
                end
                else
                begin
                    next_s.fc[i].addr = s.fc[i].addr + 13'h0001;
                end
            end
        end

        if (cmd_valid)
        begin
            mask = cmd.arr ? boot_remap_pkg::DF_PAGE_MASK
                           : boot_remap_pkg::PF_PAGE_MASK;
            last = cmd.arr ? boot_remap_pkg::DF_LAST
                           : boot_remap_pkg::PF_LAST;
            base = cmd.addr & ~mask;
            // one operation at a time over both arrays [RQ19]
            if (s.busy != 2'b00 || s.fc[0].busy || s.fc[1].busy
                || s.boot == boot_remap_pkg::BOOT_SCAN || cmd.addr > last)
            begin
                next_s.refused = 1'b1;
            end
            else
            begin
                next_s.fc[cmd.arr].op   = cmd.op;
                next_s.fc[cmd.arr].data = cmd.data;
                case (cmd.op)
                    boot_remap_pkg::OP_PROG:
                    begin
                        next_s.fc[cmd.arr].busy = 1'b1; // [RQ10]
                        next_s.fc[cmd.arr].addr = cmd.addr;
                        next_s.fc[cmd.arr].last = cmd.addr;
                    end
                    boot_remap_pkg::OP_PAGE:
                    begin
                        next_s.fc[cmd.arr].busy = 1'b1; // [RQ11] [RQ12] [RQ15]
                        next_s.fc[cmd.arr].addr = base;
                        next_s.fc[cmd.arr].last = base | mask;
                    end
                    boot_remap_pkg::OP_MASS:
                    begin
                        next_s.fc[cmd.arr].busy = 1'b1; // [RQ15]
                        next_s.fc[cmd.arr].addr = 13'h0000;
                        next_s.fc[cmd.arr].last = last;
                    end
                    default:
                    begin
                        next_s.refused = 1'b1;
                    end
                endcase
            end
        end

        case (s.boot)
            boot_remap_pkg::BOOT_SCAN:
            begin
                if (!s.sdone)
                begin
                    next_s.port[0].en   = 1'b1; // [RQ1]
                    next_s.port[0].addr = s.sidx;
                    next_s.sidx         = s.sidx + 13'h0001;
                    next_s.sdone        = (s.sidx == boot_remap_pkg::CKSUM_IDX);
                end
                next_s.rv   = s.port[0].en & ~s.port[0].we;
                next_s.ridx = s.port[0].addr;
                if (s.rv)
                begin
                    if (s.ridx == boot_remap_pkg::CKSUM_IDX)
                    begin
                        // zero word never matches [RQ16] [RQ21]
                        ok              = (pf_rdata == s.sum) && (pf_rdata != 32'h0);
                        next_s.cksum_ok = ok;
                        next_s.boot     = ok ? boot_remap_pkg::BOOT_NORMAL
                                             : boot_remap_pkg::BOOT_ROM; // [RQ2] [RQ7]
                    end
                    else
                    begin
                        next_s.sum = s.sum + pf_rdata; // [RQ21]
                    end
                end
            end
            boot_remap_pkg::BOOT_ROM:
            begin
                if (goto_flash)
                begin
                    next_s.boot = boot_remap_pkg::BOOT_NORMAL; // [RQ7]
                end
            end
            boot_remap_pkg::BOOT_NORMAL:
            begin
                next_s.boot = boot_remap_pkg::BOOT_NORMAL;
            end
            default:
            begin
                next_s.boot = boot_remap_pkg::BOOT_ROM;
            end
        endcase

        next_s.rom_mode = (next_s.boot != boot_remap_pkg::BOOT_NORMAL);
        next_s.busy[0]  = next_s.fc[0].busy | next_s.port[0].we;
        next_s.busy[1]  = next_s.fc[1].busy | next_s.port[1].we;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s          <= '0;
            s.boot     <= boot_remap_pkg::BOOT_SCAN; // [RQ1]
            s.rom_mode <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign dec         = s.dec;
    assign rom_mode    = s.rom_mode;
    assign cksum_ok    = s.cksum_ok;
    assign pf_port     = s.port[0];
    assign df_port     = s.port[1];
    assign busy        = s.busy;
    assign cmd_refused = s.refused;
    assign cmd_done    = s.done;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_scan_rom;
        s.boot == boot_remap_pkg::BOOT_SCAN |-> s.rom_mode && !s.cksum_ok;
    endproperty
    a_scan_rom: assert property (p_scan_rom) // [RQ1]
        else $error("checksum scan outside rom mode");

    property p_rom_alias;
        cpu_req && !cpu_we && s.boot != boot_remap_pkg::BOOT_NORMAL
            && cpu_addr <= boot_remap_pkg::ROM_MIRROR_HI
        |=> s.dec.sel == boot_remap_pkg::SEL_ROM
            && s.dec.offs[11:0] == $past(cpu_addr[11:0]);
    endproperty
    a_rom_alias: assert property (p_rom_alias) // [RQ3]
        else $error("rom mirror decode wrong");

    property p_pf_rom;
        cpu_req && !cpu_we && s.boot == boot_remap_pkg::BOOT_ROM
            && !s.busy[0] && !s.fc[0].busy
            && cpu_addr >= boot_remap_pkg::PF_LO && cpu_addr <= boot_remap_pkg::PF_HI
        |=> s.dec.sel == boot_remap_pkg::SEL_PF && s.dec.offs == $past(cpu_addr[14:0]);
    endproperty
    a_pf_rom: assert property (p_pf_rom) // [RQ4]
        else $error("program flash decode wrong");

    property p_df_rom;
        cpu_req && !cpu_we && s.boot != boot_remap_pkg::BOOT_NORMAL
            && !s.busy[1] && !s.fc[1].busy
            && cpu_addr >= boot_remap_pkg::DF_LO && cpu_addr <= boot_remap_pkg::DF_HI
        |=> s.dec.sel == boot_remap_pkg::SEL_DF;
    endproperty
    a_df_rom: assert property (p_df_rom) // [RQ5]
        else $error("data flash decode wrong");

    property p_ram;
        cpu_req && cpu_addr >= boot_remap_pkg::RAM_LO && cpu_addr <= boot_remap_pkg::RAM_HI
        |=> s.dec.sel == boot_remap_pkg::SEL_RAM && !s.dec.err;
    endproperty
    a_ram: assert property (p_ram) // [RQ6]
        else $error("ram decode wrong");

    property p_busy_read;
        cpu_req && s.busy[1] && cpu_addr >= boot_remap_pkg::DF_LO
            && cpu_addr <= boot_remap_pkg::DF_HI
        |=> s.dec.err && s.dec.sel == 4'h0;
    endproperty
    a_busy_read: assert property (p_busy_read) // [RQ9]
        else $error("busy flash was readable");

    property p_one_op;
        !(s.busy[0] && s.busy[1]);
    endproperty
    a_one_op: assert property (p_one_op) // [RQ19]
        else $error("two flash operations at once");

    property p_erase_ones;
        s.port[0].we && s.fc[0].op != boot_remap_pkg::OP_PROG
        |-> s.port[0].wdata == boot_remap_pkg::ERASED;
    endproperty
    a_erase_ones: assert property (p_erase_ones) // [RQ13]
        else $error("erase wrote a zero bit");

    property p_zero_cksum;
        s.boot == boot_remap_pkg::BOOT_SCAN && s.rv
            && s.ridx == boot_remap_pkg::CKSUM_IDX && pf_rdata == 32'h0
        |=> s.rom_mode && !s.cksum_ok;
    endproperty
    a_zero_cksum: assert property (p_zero_cksum) // [RQ16]
        else $error("zero checksum left rom mode");

    property p_match;
        s.boot == boot_remap_pkg::BOOT_SCAN && s.rv
            && s.ridx == boot_remap_pkg::CKSUM_IDX
            && pf_rdata == s.sum && pf_rdata != 32'h0
        |=> !s.rom_mode && s.cksum_ok;
    endproperty
    a_match: assert property (p_match) // [RQ2]
        else $error("matching checksum not taken");

    property p_goto;
        s.boot == boot_remap_pkg::BOOT_ROM && goto_flash |=> !s.rom_mode ##1 !s.rom_mode;
    endproperty
    a_goto: assert property (p_goto) // [RQ7]
        else $error("transfer command ignored");

    property p_page;
        cmd_valid && cmd.op == boot_remap_pkg::OP_PAGE && !cmd.arr
            && s.busy == 2'b00 && !s.fc[0].busy && !s.fc[1].busy
            && s.boot != boot_remap_pkg::BOOT_SCAN
        |=> s.fc[0].busy && s.fc[0].addr == {$past(cmd.addr[12:8]), 8'h00}
            && s.fc[0].last == {$past(cmd.addr[12:8]), 8'hFF};
    endproperty
    a_page: assert property (p_page) // [RQ12]
        else $error("program flash page bounds wrong");

endmodule

`default_nettype wire

// [pflash_model.sv]
// program flash array model answering the sequencer port
`timescale 1ns/1ps
`default_nettype none

module pflash_model
(
    input  wire logic                        clk,
    input  wire boot_remap_pkg::flash_port_t port,
    output logic [31:0]                      rdata
);
    logic [31:0] mem [0:8191];
    logic [31:0] junk = 32'hA5A5A5A5;

    // address taken at the edge, word shown the next cycle; junk when no read
    always @(posedge clk)
    begin
        junk <= ~junk;
        if (port.en && port.we)
            mem[port.addr] <= port.wdata;
        rdata <= (port.en && !port.we) ? mem[port.addr] : junk;
    end
endmodule

`default_nettype wire

// [tb_boot_checksum_memory_remap.sv]
// self-checking bench for boot remap and flash sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_boot_checksum_memory_remap;
    logic                        clk = 1'b0;
    logic                        rst_b = 1'b0;
    logic                        cpu_req = 1'b0;
    logic                        cpu_we = 1'b0;
    logic [16:0]                 cpu_addr = 17'h00000;
    logic                        goto_flash = 1'b0;
    logic                        cmd_valid = 1'b0;
    boot_remap_pkg::flash_cmd_t  cmd = '0;
    logic [31:0]                 pf_rdata;
    boot_remap_pkg::bus_dec_t    dec;
    logic                        rom_mode;
    logic                        cksum_ok;
    boot_remap_pkg::flash_port_t pf_port;
    boot_remap_pkg::flash_port_t df_port;
    logic [1:0]                  busy;
    logic                        cmd_refused;
    logic                        cmd_done;
    int                          errors = 0;
    int                          total_checks = 0;
    int                          cycles = 0;

    always #4 clk = ~clk;

    boot_checksum_memory_remap dut
    (
        .clk         (clk),
        .rst_b       (rst_b),
        .cpu_req     (cpu_req),
        .cpu_we      (cpu_we),
        .cpu_addr    (cpu_addr),
        .goto_flash  (goto_flash),
        .cmd_valid   (cmd_valid),
        .cmd         (cmd),
        .pf_rdata    (pf_rdata),
        .dec         (dec),
        .rom_mode    (rom_mode),
        .cksum_ok    (cksum_ok),
        .pf_port     (pf_port),
        .df_port     (df_port),
        .busy        (busy),
        .cmd_refused (cmd_refused),
        .cmd_done    (cmd_done)
    );

    pflash_model pf
    (
        .clk   (clk),
        .port  (pf_port),
        .rdata (pf_rdata)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            $display("CHECK FAILED at %0t: run too long", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_dec(input logic [3:0] sel, input logic [14:0] offs, input logic err);
        total_checks++;
        if ({dec.sel, dec.offs, dec.err} !== {sel, offs, err})
        begin
            errors++;
            $display("CHECK FAILED at %0t: decode %h exp %h", $time, dec, {sel, offs, err});
        end
    endtask

    function automatic logic [31:0] pat(input int i);
        return 32'hC3000000 ^ i;
    endfunction

    task automatic preload(input logic good);
        logic [31:0] s;
        s = 32'h00000000;
        for (int i = 0; i < 8191; i++)
        begin
            pf.mem[i] = pat(i);
            s += pat(i);
        end
        pf.mem[8191] = good ? s : 32'h00000000;
    endtask

    task automatic bus(input logic [16:0] a, input logic we, input logic [3:0] sel,
                       input logic [14:0] offs, input logic err);
        @(posedge clk);
        cpu_req  <= 1'b1;
        cpu_we   <= we;
        cpu_addr <= a;
        @(posedge clk);
        cpu_req  <= 1'b0;
        cpu_we   <= 1'b0;
        #1;
        chk_dec(sel, offs, err);
    endtask

    task automatic send(input boot_remap_pkg::flash_op_t op, input logic arr,
                        input logic [12:0] a, input logic [31:0] d, input logic acc);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= '{op: op, arr: arr, addr: a, data: d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        if (acc)
            chk({31'h0, busy[arr]}, 32'h1, "busy after accept");
        else
            chk({31'h0, cmd_refused}, 32'h1, "refusal pulse");
    endtask

    task automatic drain(input logic arr, input logic [12:0] lo, input logic [12:0] hi,
                         input logic [31:0] d, output int n, output int dn);
        boot_remap_pkg::flash_port_t p;
        n = 0;
        dn = 0;
        for (int i = 0; i < 20000 && busy !== 2'b00; i++)
        begin
            @(posedge clk);
            #1;
            p = arr ? df_port : pf_port;
            if (p.en === 1'b1 && p.we === 1'b1)
                n += (p.addr >= lo && p.addr <= hi && p.wdata === d) ? 1 : 10000;
            if (cmd_done === 1'b1)
                dn++;
        end
        chk({30'h0, busy}, 32'h0, "busy stuck");
    endtask

    task automatic t_scan();
        bus(17'h0F010, 1'b0, 4'h1, 15'h0010, 1'b0);
        bus(17'h10000, 1'b0, 4'h0, 15'h0000, 1'b1);
        send(boot_remap_pkg::OP_PROG, 1'b1, 13'h0000, 32'h0, 1'b0);
        repeat (8300) @(posedge clk);
        #1;
        chk({30'h0, rom_mode, cksum_ok}, 32'h2, "zero checksum");
        $display("test scan done");
    endtask

    task automatic t_map();
        bus(17'h00FFF, 1'b0, 4'h1, 15'h0FFF, 1'b0);
        bus(17'h10000, 1'b0, 4'h2, 15'h0000, 1'b0);
        bus(17'h17FFF, 1'b0, 4'h2, 15'h7FFF, 1'b0);
        bus(17'h18000, 1'b0, 4'h0, 15'h0000, 1'b1);
        bus(17'h18800, 1'b0, 4'h4, 15'h0000, 1'b0);
        bus(17'h18FFF, 1'b0, 4'h4, 15'h07FF, 1'b0);
        bus(17'h19000, 1'b1, 4'h8, 15'h0000, 1'b0);
        bus(17'h19FFF, 1'b0, 4'h8, 15'h0FFF, 1'b0);
        bus(17'h1A000, 1'b0, 4'h0, 15'h0000, 1'b1);
        bus(17'h00010, 1'b1, 4'h0, 15'h0000, 1'b1);
        $display("test map done");
    endtask

    task automatic t_flash();
        int n;
        int dn;
        send(boot_remap_pkg::OP_PAGE, 1'b0, 13'h0023, 32'h0, 1'b1);
        send(boot_remap_pkg::OP_PROG, 1'b1, 13'h0000, 32'h0, 1'b0);
        bus(17'h10000, 1'b0, 4'h0, 15'h0000, 1'b1);
        bus(17'h18800, 1'b0, 4'h4, 15'h0000, 1'b0);
        bus(17'h19010, 1'b0, 4'h8, 15'h0010, 1'b0);
        drain(1'b0, 13'h0000, 13'h00FF, 32'hFFFFFFFF, n, dn);
        for (int i = 0; i < 258; i++)
            chk(pf.mem[i], (i < 256) ? 32'hFFFFFFFF : pat(i), "page");
        send(boot_remap_pkg::OP_PROG, 1'b0, 13'h0005, 32'h12345678, 1'b1);
        drain(1'b0, 13'h0005, 13'h0005, 32'h12345678, n, dn);
        chk(n, 32'd1, "word count");
        chk(dn, 32'd1, "done pulse");
        chk(pf.mem[5], 32'h12345678, "word");
        send(boot_remap_pkg::OP_PAGE, 1'b1, 13'h000B, 32'h0, 1'b1);
        drain(1'b1, 13'h0008, 13'h000F, 32'hFFFFFFFF, n, dn);
        chk(n, 32'd8, "df page");
        send(boot_remap_pkg::OP_MASS, 1'b1, 13'h0000, 32'h0, 1'b1);
        drain(1'b1, 13'h0000, 13'h01FF, 32'hFFFFFFFF, n, dn);
        chk(n, 32'd512, "df mass");
        chk(dn, 32'd1, "mass done");
        send(boot_remap_pkg::OP_PAGE, 1'b1, 13'h01F0, 32'h0, 1'b1);
        bus(17'h18800, 1'b0, 4'h0, 15'h0000, 1'b1);
        drain(1'b1, 13'h01F0, 13'h01F7, 32'hFFFFFFFF, n, dn);
        send(boot_remap_pkg::OP_PROG, 1'b1, 13'h0200, 32'h0, 1'b0);
        send(boot_remap_pkg::flash_op_t'(2'h3), 1'b0, 13'h0000, 32'h0, 1'b0);
        chk({30'h0, busy}, 32'h0, "refused left idle");
        $display("test flash done");
    endtask

    task automatic t_goto();
        @(posedge clk);
        goto_flash <= 1'b1;
        @(posedge clk);
        goto_flash <= 1'b0;
        #1;
        chk({31'h0, rom_mode}, 32'h0, "transfer command");
        bus(17'h00010, 1'b0, 4'h2, 15'h0010, 1'b0);
        bus(17'h10010, 1'b0, 4'h1, 15'h0010, 1'b0);
        bus(17'h19004, 1'b1, 4'h8, 15'h0004, 1'b0);
        $display("test goto done");
    endtask

    task automatic t_good();
        @(posedge clk);
        rst_b <= 1'b0;
        preload(1'b1);
        repeat (8) @(posedge clk);
        chk({31'h0, rom_mode}, 32'h1, "rom mode in reset");
        rst_b <= 1'b1;
        for (int i = 0; i < 9000 && cksum_ok !== 1'b1; i++)
            @(posedge clk);
        #1;
        chk({30'h0, rom_mode, cksum_ok}, 32'h1, "good checksum");
        bus(17'h00000, 1'b0, 4'h2, 15'h0000, 1'b0);
        $display("test good boot done");
    endtask

    initial
    begin
        preload(1'b0);
        repeat (8) @(posedge clk);
        chk({31'h0, rom_mode}, 32'h1, "rom mode in reset");
        rst_b <= 1'b1;
        t_scan();
        t_map();
        t_flash();
        t_goto();
        t_good();
        end_sim();
    end
endmodule

`default_nettype wire
